/* src/adc_burst_ctl.sv */
`timescale 1ns/100ps
module adc_burst_ctl
	import adc_ctl_pkg::*;
(
	input  wire logic        hclk,            // Bus and oscillator clock, 40 MHz
	input  wire logic        hresetn,         // Async reset, active low
	input  wire logic        hsel,            // Slave select
	input  wire logic [11:0] haddr,           // Byte address
	input  wire logic [1:0]  htrans,          // Transfer type
	input  wire logic        hwrite,          // Write when high
	input  wire logic [2:0]  hsize,           // Transfer size, word only
	input  wire logic [31:0] hwdata,          // Write data
	input  wire logic        hready,          // Bus ready
	output logic             hreadyout,       // Slave ready
	output logic [31:0]      hrdata,          // Read data
	output logic             hresp,           // Always OKAY
	input  wire logic        converter_clock, // Converter clock pin
	input  wire logic        conv_trigger,    // Start-of-conversion pulse
	input  wire logic        conv_done,       // End-of-conversion pulse
	input  wire logic [15:0] conv_data,       // Conversion result
	output logic             conv_start,      // Begin conversion pulse
	output logic             tracking         // Sampling input, level
);
	logic [15:0]  acc_reg;
	logic [5:0]   burst_track_field;
	logic [3:0]   powerup_time_field;
	logic [2:0]   shift_justify_field;
	logic         accumulate_enable_bit;
	logic         burst_en_reg;
	logic         delayed_track_select;
	logic [2:0]   repeat_reg;
	logic [7:0]   gt_high_reg;
	seq_state_e   state_reg;
	logic [2:0]   remain_reg;
	logic         first_reg;
	logic         wr_pend_reg;
	logic         rd_pend_reg;
	logic [9:0]   idx_reg;
	logic         sar_s1_reg;
	logic         sar_s2_reg;
	logic         sar_s3_reg;
	logic         sar_rise;
	logic         timer_load;
	logic [6:0]   timer_value;
	logic         expire;
	logic [15:0]  fmt_val;
	logic [31:0]  rdata_next;
	logic         addr_phase;
	logic         wr_data;
	logic         more_conv;

	// Formats the accumulator for reads
	function automatic logic [15:0] format_acc(input logic [15:0] v, input logic [2:0] m);
		logic [15:0] r;
		r = v;
		unique case (m)
			3'h0: r = v;
			3'h1: r = v >> 1;
			3'h2: r = v >> 2;
			3'h3: r = v >> 3;
			3'h4: r = v << LJ_SHIFT;
			default: r = v;
		endcase
		return r;
	endfunction

	// Bus decode
	assign addr_phase = hsel && htrans[1] && hready;
	assign wr_data    = wr_pend_reg;
	assign fmt_val    = format_acc(acc_reg, shift_justify_field); // RQ9 RQ11
	assign more_conv  = burst_en_reg && (remain_reg != 3'h0);
	assign sar_rise   = sar_s2_reg && !sar_s3_reg;

	// Converter clock synchroniser and edge
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			sar_s1_reg <= 1'b0;
			sar_s2_reg <= 1'b0;
			sar_s3_reg <= 1'b0;
		end
		else
		begin
			sar_s1_reg <= converter_clock;
			sar_s2_reg <= sar_s1_reg;
			sar_s3_reg <= sar_s2_reg;
		end
	end

	// Address phase capture; reads insert one wait state
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
			idx_reg     <= 10'h000;
			hreadyout   <= 1'b1;
			hrdata      <= 32'h0000_0000;
			hresp       <= 1'b0;
		end
		else
		begin
			hresp       <= 1'b0;
			wr_pend_reg <= addr_phase && hwrite;
			if (addr_phase)
				idx_reg <= haddr[11:2];
			if (addr_phase && !hwrite)
			begin
				rd_pend_reg <= 1'b1;
				hreadyout   <= 1'b0;
			end
			else if (rd_pend_reg)
			begin
				rd_pend_reg <= 1'b0;
				hreadyout   <= 1'b1;
				hrdata      <= rdata_next;
			end
		end
	end

	// Read mux; unmapped indices read zero
	always_comb
	begin
		rdata_next = 32'h0000_0000;
		unique case (idx_reg)
			IDX_ACCUM_CFG:  rdata_next[5:3] = shift_justify_field; // Enable bit reads zero
			IDX_POWER:      rdata_next[3:0] = powerup_time_field;
			IDX_TRACK_TIME: rdata_next[5:0] = burst_track_field;
			IDX_CTRL:       rdata_next[4:0] = {repeat_reg, delayed_track_select, burst_en_reg};
			IDX_STATUS:     rdata_next[5:0] = {first_reg, remain_reg, state_reg};
			IDX_GT_HIGH:    rdata_next[7:0] = gt_high_reg; // RQ13
			IDX_RES_LOW:    rdata_next[7:0] = fmt_val[7:0]; // RQ7
			IDX_RES_HIGH:   rdata_next[7:0] = fmt_val[15:8]; // RQ5
			default:        rdata_next = 32'h0000_0000;
		endcase
	end

	// Configuration registers
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			burst_track_field     <= TRACK_RST;
			powerup_time_field    <= POWER_RST;
			shift_justify_field   <= SJST_RST;
			accumulate_enable_bit <= 1'b0;
			burst_en_reg          <= 1'b0;
			delayed_track_select  <= 1'b0;
			repeat_reg            <= 3'h0;
			gt_high_reg           <= GT_RST;
		end
		else if (wr_data)
		begin
			unique case (idx_reg)
				IDX_ACCUM_CFG:
				begin
					shift_justify_field   <= hwdata[SJST_LSB +: 3]; // RQ11
					accumulate_enable_bit <= hwdata[ACCEN_BIT];
				end
				IDX_POWER:      powerup_time_field <= hwdata[3:0];
				IDX_TRACK_TIME: burst_track_field <= hwdata[5:0]; // RQ1
				IDX_CTRL:
				begin
					burst_en_reg         <= hwdata[BURST_BIT];
					delayed_track_select <= hwdata[DELAY_BIT];
					repeat_reg           <= hwdata[REPEAT_LSB +: 3];
				end
				IDX_GT_HIGH:    gt_high_reg <= hwdata[7:0]; // RQ13
				default:        gt_high_reg <= gt_high_reg;
			endcase
		end
	end

	// Accumulator: software preset wins over a conversion landing
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			acc_reg <= ACC_RST; // RQ10
		else if (wr_data && idx_reg == IDX_RES_HIGH)
			acc_reg[15:8] <= hwdata[7:0]; // RQ6
		else if (wr_data && idx_reg == IDX_RES_LOW)
			acc_reg[7:0] <= hwdata[7:0]; // RQ8 RQ12
		else if (conv_done && state_reg == ST_CONVERT)
		begin
			if (burst_en_reg ? first_reg : !accumulate_enable_bit)
				acc_reg <= conv_data;
			else
				acc_reg <= acc_reg + conv_data;
		end
	end

	// Delay selection: power-up before the first in burst mode (none otherwise), tracking between
	always_comb
	begin
		timer_load  = 1'b0;
		timer_value = 7'h00;
		if (state_reg == ST_IDLE && conv_trigger)
		begin
			timer_load  = 1'b1;
			timer_value = burst_en_reg ? {powerup_time_field, 3'b000} : 7'h00; // RQ4
		end
		else if (state_reg == ST_CONVERT && conv_done && more_conv)
		begin
			timer_load  = 1'b1;
			timer_value = TRACK_BASE - {1'b0, burst_track_field}; // RQ2 RQ14
		end
	end

	track_timer u_timer (
		.hclk       (hclk),
		.hresetn    (hresetn),
		.load       (timer_load),
		.load_value (timer_value),
		.extra_en   (delayed_track_select),
		.sar_rise   (sar_rise),
		.expire     (expire)
	);

	// Burst sequencer
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_reg  <= ST_IDLE;
			remain_reg <= 3'h0;
			first_reg  <= 1'b0;
			conv_start <= 1'b0;
			tracking   <= 1'b0;
		end
		else
		begin
			conv_start <= 1'b0;
			unique case (state_reg)
				ST_IDLE:
					if (conv_trigger)
					begin
						state_reg  <= ST_POWER; // RQ4
						remain_reg <= repeat_reg;
						first_reg  <= 1'b1;
						tracking   <= 1'b1;
					end
				ST_POWER, ST_TRACK:
					if (expire)
					begin
						state_reg  <= ST_CONVERT;
						conv_start <= 1'b1; // RQ14
						tracking   <= 1'b0;
					end
				ST_CONVERT:
					if (conv_done)
					begin
						first_reg <= 1'b0;
						if (more_conv)
						begin
							state_reg  <= ST_TRACK; // RQ14
							remain_reg <= remain_reg - 3'h1;
							tracking   <= 1'b1;
						end
						else
							state_reg <= ST_IDLE;
					end
			endcase
		end
	end

	// Checking helpers: phase length and latched expectations
	logic [15:0] ph_cnt;
	logic [6:0]  len_lat;
	logic        delay_lat;
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ph_cnt    <= 16'h0000;
			len_lat   <= 7'h00;
			delay_lat <= 1'b0;
		end
		else if (timer_load)
		begin
			ph_cnt    <= 16'h0000;
			len_lat   <= (timer_value == 7'h00) ? 7'h01 : timer_value;
			delay_lat <= delayed_track_select;
		end
		else
			ph_cnt <= ph_cnt + 16'h0001;
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	track_delay_a: assert property ( // RQ2
		(state_reg == ST_TRACK && expire && !delay_lat) |-> ph_cnt == {9'h000, len_lat})
		else $error("burst tracking delay length wrong");
	extra_delay_a: assert property ( // RQ3
		(state_reg == ST_TRACK && expire && delay_lat) |-> ph_cnt >= {9'h000, len_lat} + 16'h0003)
		else $error("delayed track cycles missing");
	first_power_a: assert property ( // RQ4
		(state_reg == ST_POWER && expire && !delay_lat && burst_en_reg)
		|-> ph_cnt == {9'h000, len_lat})
		else $error("first conversion not timed by power-up field");
	read_high_a: assert property ( // RQ5
		(rd_pend_reg && idx_reg == IDX_RES_HIGH) |=> hrdata == {24'h000000, $past(fmt_val[15:8])})
		else $error("high byte read mismatch");
	read_low_a: assert property ( // RQ7
		(rd_pend_reg && idx_reg == IDX_RES_LOW) |=> hrdata == {24'h000000, $past(fmt_val[7:0])} && hreadyout)
		else $error("low byte read mismatch");
	write_high_a: assert property ( // RQ6
		(wr_pend_reg && idx_reg == IDX_RES_HIGH) |=> acc_reg[15:8] == $past(hwdata[7:0]))
		else $error("high byte write not loaded");
	write_low_a: assert property ( // RQ8
		(wr_pend_reg && idx_reg == IDX_RES_LOW) |=> acc_reg[7:0] == $past(hwdata[7:0]))
		else $error("low byte write not loaded");
	shift_zero_a: assert property ( // RQ9
		(shift_justify_field != 3'h0 && shift_justify_field < SJST_LEFT) |-> fmt_val[15] == 1'b0)
		else $error("shifted read top bit not zero");
	justify_code_a: assert property ( // RQ11
		(shift_justify_field > SJST_LEFT) |-> fmt_val == acc_reg)
		else $error("reserved justify code altered data");
	reload_a: assert property ( // RQ14
		(state_reg == ST_CONVERT && conv_done && more_conv) |=> state_reg == ST_TRACK && ph_cnt == 16'h0000)
		else $error("tracking counter not reloaded");

	burst_cov_c: cover property (state_reg == ST_TRACK && expire);
	delayed_cov_c: cover property (state_reg == ST_TRACK && expire && delay_lat);
	preset_cov_c: cover property (wr_pend_reg && idx_reg == IDX_RES_HIGH);
	left_cov_c: cover property (rd_pend_reg && shift_justify_field == SJST_LEFT);
endmodule

/* src/adc_ctl_pkg.sv */
// Contract
// RQ1: Software keeps track-time bits 7:6 at reset value; only bits 5:0 set the delay.
// RQ2: Burst tracking delay between conversions is 64 minus track field oscillator periods.
// RQ3: Delayed-track mode adds three converter clock cycles to each burst tracking delay.
// RQ4: No burst tracking delay before the first conversion; power-up time governs it instead.
// RQ5: High data read returns upper byte of the formatted 16-bit accumulator.
// RQ6: High data write loads the byte into the accumulator upper half.
// RQ7: Low data read returns lower byte of the formatted 16-bit accumulator.
// RQ8: Low data write loads the byte into the accumulator lower half.
// RQ9: Right shift fills vacated most significant read bits with zeros.
// RQ10: Both data bytes reset to zero and are readable and writable.
// RQ11: Justify field selects right shift 0..3 or left justify; other codes reserved.
// RQ12: With accumulation outside burst, software clears result by writing zero to both bytes.
// RQ13: Greater-than high register holds the top byte of the 16-bit threshold.
// RQ14: Tracking counter reloads at each burst conversion end and starts the next on expiry.
package adc_ctl_pkg;
	// Register indices; byte address is four times the index
	localparam logic [9:0] IDX_ACCUM_CFG  = 10'h0BA;
	localparam logic [9:0] IDX_POWER      = 10'h0BB;
	localparam logic [9:0] IDX_TRACK_TIME = 10'h0BC;
	localparam logic [9:0] IDX_CTRL       = 10'h0C0;
	localparam logic [9:0] IDX_STATUS     = 10'h0C1;
	localparam logic [9:0] IDX_GT_HIGH    = 10'h0C4;
	localparam logic [9:0] IDX_RES_LOW    = 10'h0D2;
	localparam logic [9:0] IDX_RES_HIGH   = 10'h0D3;
	// Reset values
	localparam logic [5:0]  TRACK_RST  = 6'h1E;
	localparam logic [3:0]  POWER_RST  = 4'hF;
	localparam logic [7:0]  GT_RST     = 8'hFF;
	localparam logic [15:0] ACC_RST    = 16'h0000;
	localparam logic [2:0]  SJST_RST   = 3'h0;
	// Field positions
	localparam int SJST_LSB    = 3;
	localparam int ACCEN_BIT   = 6;
	localparam int BURST_BIT   = 0;
	localparam int DELAY_BIT   = 1;
	localparam int REPEAT_LSB  = 2;
	// Justify codes
	localparam logic [2:0] SJST_LEFT = 3'h4;
	// Timing counts: TRACK_BASE in fast oscillator periods (hclk is the oscillator), DELAY_SARCLKS in converter clocks
	localparam logic [6:0] TRACK_BASE    = 7'h40;
	localparam int         PWR_SCALE_SH  = 3;
	localparam logic [1:0] DELAY_SARCLKS = 2'h3;
	localparam int         RESULT_BITS   = 10;
	localparam int         LJ_SHIFT      = 16 - RESULT_BITS;
	// Sequencer states
	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_POWER   = 2'b01,
		ST_CONVERT = 2'b10,
		ST_TRACK   = 2'b11
	} seq_state_e;
endpackage

/* src/track_timer.sv */
`timescale 1ns/100ps
module track_timer
	import adc_ctl_pkg::*;
(
	input  wire logic       hclk,       // Fast oscillator clock
	input  wire logic       hresetn,    // Async reset, active low
	input  wire logic       load,       // Start a new delay
	input  wire logic [6:0] load_value, // Delay in oscillator periods
	input  wire logic       extra_en,   // Add converter clock cycles
	input  wire logic       sar_rise,   // Converter clock rising edge
	output logic            expire      // One-cycle end of delay
);
	logic [6:0] cnt_reg;
	logic [1:0] ext_reg;
	logic       run_reg;

	// Oscillator count first, then converter clock edges
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cnt_reg <= 7'h00;
			ext_reg <= 2'h0;
			run_reg <= 1'b0;
			expire  <= 1'b0;
		end
		else if (load)
		begin
			cnt_reg <= load_value;
			ext_reg <= extra_en ? DELAY_SARCLKS : 2'h0; // RQ3
			run_reg <= 1'b1;
			expire  <= 1'b0;
		end
		else if (run_reg)
		begin
			if (cnt_reg > 7'h01)
			begin
				cnt_reg <= cnt_reg - 7'h01; // RQ2
				expire  <= 1'b0;
			end
			else if (ext_reg != 2'h0)
			begin
				if (sar_rise)
					ext_reg <= ext_reg - 2'h1; // RQ3
				expire <= 1'b0;
			end
			else
			begin
				expire  <= 1'b1; // RQ14
				run_reg <= 1'b0;
				cnt_reg <= 7'h00;
			end
		end
		else
			expire <= 1'b0;
	end
endmodule

/* tb/adc_burst_track_and_result_access_tb.sv */
`timescale 1ns/100ps
module adc_burst_track_and_result_access_tb
	import adc_ctl_pkg::*;
;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [11:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [31:0] hwdata;
	wire         hready;
	logic        hreadyout;
	logic [31:0] hrdata;
	logic        hresp;
	logic        converter_clock;
	logic        conv_trigger;
	logic        conv_done;
	logic        conv_start;
	logic        tracking;
	logic [1:0]  sar_div;
	logic [31:0] rd;
	logic [15:0] acc;
	int          fail_count;
	int          check_count;
	int          f1, f2, f3, b1, b2, b3, b4;

	// Byte addresses from register indices
	localparam logic [11:0] A_CFG = {IDX_ACCUM_CFG, 2'b00};
	localparam logic [11:0] A_PWR = {IDX_POWER, 2'b00};
	localparam logic [11:0] A_TRK = {IDX_TRACK_TIME, 2'b00};
	localparam logic [11:0] A_CTL = {IDX_CTRL, 2'b00};
	localparam logic [11:0] A_GTH = {IDX_GT_HIGH, 2'b00};
	localparam logic [11:0] A_LOW = {IDX_RES_LOW, 2'b00};
	localparam logic [11:0] A_HIGH = {IDX_RES_HIGH, 2'b00};

	assign hready = hreadyout;

	adc_burst_ctl DUT (
		.hclk            (hclk),
		.hresetn         (hresetn),
		.hsel            (hsel),
		.haddr           (haddr),
		.htrans          (htrans),
		.hwrite          (hwrite),
		.hsize           (3'h2),
		.hwdata          (hwdata),
		.hready          (hready),
		.hreadyout       (hreadyout),
		.hrdata          (hrdata),
		.hresp           (hresp),
		.converter_clock (converter_clock),
		.conv_trigger    (conv_trigger),
		.conv_done       (conv_done),
		.conv_data       (16'h0000),
		.conv_start      (conv_start),
		.tracking        (tracking)
	);

	// 40 MHz clock
	initial
	begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end

	// Converter clock, eight oscillator periods
	always @(posedge hclk)
	begin
		sar_div <= sar_div + 2'h1;
		if (sar_div == 2'h3)
			converter_clock <= ~converter_clock;
	end

	// Compare and count
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One AHB single transfer, address then data phase
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		int waits;
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		waits = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
		begin
			@(posedge hclk);
			waits++;
		end
		rd = hrdata;
		check("wait_states", waits, w ? 32'd0 : 32'd1);
		check("hresp", {31'h0, hresp}, 32'h0);
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		bus(1'b1, a, {24'h0, d});
	endtask

	task automatic rdchk(input string name, input logic [11:0] a, input logic [7:0] exp);
		bus(1'b0, a, 32'h0);
		check(name, rd, {24'h0, exp});
	endtask

	// Pulse trigger or done, count edges until the start pulse
	task automatic measure(input bit from_done, output int cyc);
		@(posedge hclk);
		if (from_done)
			conv_done <= 1'b1;
		else
			conv_trigger <= 1'b1;
		@(posedge hclk);
		conv_done <= 1'b0;
		conv_trigger <= 1'b0;
		cyc = 0;
		while (conv_start !== 1'b1)
		begin
			@(posedge hclk);
			cyc++;
			if (cyc == 1)
				check("tracking_held", {31'h0, tracking}, 32'h1);
		end
		check("tracking_at_start", {31'h0, tracking}, 32'h0);
	endtask

	// Two-conversion burst: first latency and inter-conversion latency
	task automatic run_burst(input logic [7:0] ctl, input logic [7:0] pwr,
		input logic [7:0] trk, output int first, output int between);
		wr(A_PWR, pwr);
		wr(A_TRK, trk);
		wr(A_CTL, ctl);
		measure(1'b0, first);
		measure(1'b1, between);
		@(posedge hclk);
		conv_done <= 1'b1;
		@(posedge hclk);
		conv_done <= 1'b0;
		repeat (4) @(posedge hclk);
	endtask

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Watchdog
	initial
	begin
		repeat (20000) @(posedge hclk);
		fail_count++;
		give_verdict();
	end

	// Main sequence
	initial
	begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 12'h000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hwdata = 32'h0;
		converter_clock = 1'b0;
		sar_div = 2'h0;
		conv_trigger = 1'b0;
		conv_done = 1'b0;
		fail_count = 0;
		check_count = 0;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		// Reset values and plain access
		rdchk("low_reset", A_LOW, 8'h00);
		rdchk("high_reset", A_HIGH, 8'h00);
		rdchk("track_reset", A_TRK, 8'h1E);
		rdchk("gth_reset", A_GTH, 8'hFF);
		wr(A_GTH, 8'h5A);
		rdchk("gth_rw", A_GTH, 8'h5A);
		wr(A_TRK, 8'h3E);
		rdchk("track_rw", A_TRK, 8'h3E);
		rdchk("unmapped", 12'hFFC, 8'h00);
		$display("test registers done");
		// Accumulator halves under justify codes 0 to 5
		wr(A_LOW, 8'hCD);
		wr(A_HIGH, 8'hAB);
		for (int c = 0; c < 6; c++)
		begin
			wr(A_CFG, {2'b00, c[2:0], 3'b000});
			// Code 5 is reserved and reads the accumulator unformatted
			acc = (c == 4) ? (16'hABCD << 6) : (c == 5) ? 16'hABCD : (16'hABCD >> c);
			rdchk("high_fmt", A_HIGH, acc[15:8]);
			rdchk("low_fmt", A_LOW, acc[7:0]);
		end
		wr(A_CFG, 8'h00);
		wr(A_LOW, 8'h00);
		wr(A_HIGH, 8'h00);
		rdchk("low_clear", A_LOW, 8'h00);
		rdchk("high_clear", A_HIGH, 8'h00);
		$display("test result format done");
		// Burst tracking delays
		run_burst(8'h05, 8'h01, 8'h3E, f1, b1);
		run_burst(8'h05, 8'h01, 8'h36, f2, b2);
		run_burst(8'h05, 8'h03, 8'h36, f3, b3);
		check("track_delta", b2 - b1, 32'd8);
		check("track_same", b3 - b2, 32'd0);
		check("first_no_track", f2 - f1, 32'd0);
		check("first_powerup", f3 - f2, 32'd16);
		$display("test burst track done");
		// Delayed-track adds three converter clocks
		run_burst(8'h07, 8'h01, 8'h3E, f1, b4);
		check("delay_extra", {31'h0, (b4 - b1 >= 16) && (b4 - b1 <= 30)}, 32'h1);
		$display("test delayed track done");
		give_verdict();
	end
endmodule
